// [common/fcd_pkg.sv]
// constants, types and the register map of the flash command decoder
// assumes a 32-bit AHB-Lite bus and a write state machine on the same clock
package fcd_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] FCD_OFS_ADDR = 8'h00;
  localparam logic [7:0] FCD_OFS_WRITE = 8'h04;
  localparam logic [7:0] FCD_OFS_STATUS = 8'h08;
  localparam logic [7:0] FCD_OFS_MODES = 8'h0C;
  localparam logic [7:0] FCD_OFS_READ = 8'h10;

  // ------------------------------------------------------------------
  // command codes, low byte of the data bus
  // ------------------------------------------------------------------
  localparam logic [7:0] FCD_CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] FCD_CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] FCD_CMD_READ_IDENT = 8'h90;
  localparam logic [7:0] FCD_CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] FCD_CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] FCD_CMD_WORD_PROG = 8'h40;
  localparam logic [7:0] FCD_CMD_WORD_PROG_ALT = 8'h10;
  localparam logic [7:0] FCD_CMD_BUF_PROG = 8'hE8;
  localparam logic [7:0] FCD_CMD_FACTORY = 8'h80;
  localparam logic [7:0] FCD_CMD_ERASE = 8'h20;
  localparam logic [7:0] FCD_CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] FCD_CMD_SUSPEND = 8'hB0;

  // ------------------------------------------------------------------
  // status bits layout and reset value
  // ------------------------------------------------------------------
  localparam logic [7:0] FCD_STATUS_RESET = 8'h80;
  localparam int FCD_SB_READY = 7;
  localparam int FCD_SB_ERASE_ERR = 5;
  localparam int FCD_SB_PROG_ERR = 4;
  localparam logic [7:0] FCD_SB_SEQ_ERR = 8'h30;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int FCD_ADDR_W = 24;
  localparam int FCD_BUF_WORDS = 32;
  localparam int FCD_CNT_W = 5;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    FCD_MODE_ARRAY,
    FCD_MODE_STATUS,
    FCD_MODE_IDENT,
    FCD_MODE_QUERY
  } fcd_mode_t;

  typedef enum logic [2:0] {
    FCD_OP_NONE,
    FCD_OP_WORD,
    FCD_OP_BUFFER,
    FCD_OP_FACTORY,
    FCD_OP_ERASE
  } fcd_op_kind_t;

  // operation handed to the write state machine
  typedef struct packed {
    fcd_op_kind_t kind;
    logic [FCD_ADDR_W-1:0] addr;
    logic [15:0] data;
    logic [FCD_CNT_W-1:0] count;
  } fcd_op_t;

  // latched ahb address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } fcd_ahb_req_t;

endpackage : fcd_pkg

// [testbench/fcd_decoder_checker.sv]
// port assertions of the flash command decoder
// assumes one clock domain and arst_n as its asynchronous low-active reset
`timescale 1ns/1ns
module fcd_decoder_checker
  import fcd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic eng_busy,
  input wire logic op_start,
  input wire fcd_op_t op,
  input wire logic suspend_req
);
  // ---------------------------------
  // properties
  // ---------------------------------
  // data phase fields, seen one edge after the address phase was taken
  wire logic [7:0] wr_code = hwdata[7:0];
  wire logic [15:0] wr_word = hwdata[15:0];
  wire logic wr_take = hsel && htrans[1] && hwrite && hready && haddr[7:0] == FCD_OFS_WRITE;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus stall or error answer");
  property p_start_once; op_start |=> !op_start; endproperty
  a_start_once: assert property (p_start_once) else $error("start longer than one cycle");
  property p_start_cause; op_start |-> $past(wr_take, 2); endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without write cycle");
  property p_confirm;
    op_start && op.kind inside {FCD_OP_BUFFER, FCD_OP_FACTORY, FCD_OP_ERASE} |-> $past(wr_code) == FCD_CMD_CONFIRM;
  endproperty
  a_confirm: assert property (p_confirm) else $error("operation without confirm");
  property p_word_data; op_start && op.kind == FCD_OP_WORD |-> op.data == $past(wr_word); endproperty
  a_word_data: assert property (p_word_data) else $error("word data not latched");
  property p_op_hold; !op_start |-> $stable(op); endproperty
  a_op_hold: assert property (p_op_hold) else $error("operation changed between starts");
  property p_suspend; suspend_req |-> $past(wr_code) == FCD_CMD_SUSPEND; endproperty
  a_suspend: assert property (p_suspend) else $error("suspend without command");
  property p_idle_start; op_start |-> !$past(eng_busy); endproperty
  a_idle_start: assert property (p_idle_start) else $error("start while engine busy");
endmodule : fcd_decoder_checker

bind fcd_flash_command_decoder fcd_decoder_checker u_checker (.clock(clock), .arst_n(arst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .eng_busy(eng_busy), .op_start(op_start), .op(op), .suspend_req(suspend_req));

// [testbench/fcd_wsm_model.sv]
// behavioural write engine facing the decoder
// assumes op_start pulses once per operation; run_len is at least count plus 2
`timescale 1ns/1ns
module fcd_eng_model
  import fcd_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic op_start,
  input wire fcd_op_t op,
  input wire logic [15:0] run_len,
  input wire logic [7:0] err_mask,
  input wire logic [15:0] buf_rd_data,
  output logic eng_busy,
  output logic [7:0] eng_error_set,
  output logic [FCD_CNT_W-1:0] buf_rd_idx
);
  // ---------------------------------
  // engine timer and buffer fetch
  // ---------------------------------
  logic [15:0] left;
  logic [5:0] step;
  logic [15:0] got [0:31];
  assign buf_rd_idx = step[4:0];
  // busy from the cycle after a start; errors only ever pulsed, never cleared here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      left <= 16'h0000;
      step <= 6'h00;
      eng_busy <= 1'b0;
      eng_error_set <= 8'h00;
    end else begin
      eng_error_set <= 8'h00;
      if (op_start) begin
        left <= run_len;
        step <= 6'h00;
        eng_busy <= 1'b1;
      end else if (left > 16'h0001) begin
        left <= left - 16'h0001;
        step <= step + 6'h01;
      end else if (eng_busy) begin
        eng_busy <= 1'b0;
        eng_error_set <= err_mask;
      end
      // read data lags the index by one cycle
      if (eng_busy && op.kind == FCD_OP_BUFFER && step >= 6'h01 && step <= {1'b0, op.count} + 6'h01) begin
        got[step - 6'h01] <= buf_rd_data;
      end
    end
  end
endmodule : fcd_eng_model

// [testbench/test_flash_command_decoder.sv]
// self-checking bench of the flash command decoder as an ahb-lite master
// assumes fcd_eng_model as engine and a 250 MHz clock
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_flash_command_decoder;
  import fcd_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ce_n = 1'b1;
  logic oe_n = 1'b1;
  logic addr_valid_n = 1'b1;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [15:0] run_len = 16'h0006;
  logic [7:0] err_mask = 8'h00;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, eng_busy, op_start, suspend_req;
  logic [7:0] eng_error_set;
  logic [FCD_CNT_W-1:0] buf_rd_idx;
  logic [15:0] buf_rd_data;
  fcd_op_t op, last_op;
  int failures = 0;
  int checks_done = 0;
  int starts = 0, sus = 0;
  int s0;
  fcd_flash_command_decoder uut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .chip_enable_n(ce_n), .output_enable_n(oe_n), .address_valid_n(addr_valid_n),
    .array_data(16'h1234), .ident_data(16'h5678), .query_data(16'h009A), .eng_busy(eng_busy),
    .eng_error_set(eng_error_set), .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data), .op_start(op_start),
    .op(op), .suspend_req(suspend_req));
  fcd_eng_model engine (.clock(clock), .arst_n(arst_n), .op_start(op_start), .op(op), .run_len(run_len),
    .err_mask(err_mask), .buf_rd_data(buf_rd_data), .eng_busy(eng_busy), .eng_error_set(eng_error_set),
    .buf_rd_idx(buf_rd_idx));
  // ---------------------------------
  // bus tasks and monitors
  // ---------------------------------
  initial forever #2 clock = ~clock;
  // one word transfer; an idle cycle always precedes it, so reads see earlier writes
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // one flash write cycle, then time for the start pulse to be seen
  task automatic fw(input logic [23:0] a, input logic [15:0] d);
    bus(1'b1, FCD_OFS_ADDR, {8'h00, a});
    bus(1'b1, FCD_OFS_WRITE, {16'h0000, d});
    repeat (2) @(posedge clock);
  endtask : fw
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    `CHK(rd & m, e)
  endtask : rchk
  task automatic mchk(input int p, input logic [31:0] m);
    rchk(FCD_OFS_MODES, 32'h00000003 << (2 * p), m << (2 * p));
  endtask : mchk
  task automatic idle;
    for (int i = 0; i < 500 && eng_busy !== 1'b0; i++) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask : idle
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  always @(posedge clock) begin
    if (op_start === 1'b1) begin
      last_op <= op;
      starts <= starts + 1;
    end
    if (suspend_req === 1'b1) sus <= sus + 1;
  end
  // a hang ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    stop_test();
  end
  // ---------------------------------
  // test sequence
  // ---------------------------------
  initial begin
    logic [7:0] cmd [4] = '{FCD_CMD_READ_ARRAY, FCD_CMD_READ_STATUS, FCD_CMD_READ_IDENT, FCD_CMD_READ_QUERY};
    logic [31:0] msk [4] = '{32'h0000FFFF, 32'h000000FF, 32'h0000FFFF, 32'h000000FF};
    logic [31:0] exv [4] = '{32'h00001234, 32'h00000080, 32'h00005678, 32'h0000009A};
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    rchk(FCD_OFS_STATUS, 32'h000000FF, 32'h00000080);
    rchk(FCD_OFS_MODES, 32'h000000FF, 32'h00000000);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      fw({i[1:0], 22'h000000}, {8'h00, cmd[i]});
      mchk(i, i);
      bus(1'b1, FCD_OFS_ADDR, {8'h00, i[1:0], 22'h000000});
      rchk(FCD_OFS_READ, msk[i], exv[i]);
    end
    $display("read mode test done");
    for (int i = 0; i < 2; i++) begin
      fw(24'h400100, i ? {8'h00, FCD_CMD_WORD_PROG_ALT} : {8'h00, FCD_CMD_WORD_PROG});
      fw(24'h400155 + i, 16'hC3A0 + i);
      `CHK(last_op.kind, FCD_OP_WORD)
      `CHK(last_op.addr, 24'h400155 + i)
      mchk(1, 1);
      idle();
    end
    fw(24'h400000, 16'h00FF);
    mchk(1, 0);
    $display("word program test done");
    run_len <= 16'h0064;
    fw(24'h800000, 16'h0040);
    fw(24'h800008, 16'h0001);
    s0 = starts;
    fw(24'h800000, 16'h00FF);
    fw(24'h800000, 16'h0090);
    mchk(2, 1);
    fw(24'h800000, 16'h0040);
    fw(24'h800000, 16'h0001);
    `CHK(starts, s0)
    fw(24'h800000, 16'h00B0);
    `CHK(sus, 1)
    idle();
    fw(24'h800000, 16'h00FF);
    mchk(2, 0);
    $display("busy test done");
    run_len <= 16'h0006;
    fw(24'hC10000, 16'h0020);
    fw(24'hC20000, 16'h00D0);
    `CHK(last_op.kind, FCD_OP_ERASE)
    `CHK(last_op.addr, 24'hC20000)
    idle();
    s0 = starts;
    fw(24'h000000, 16'h0020);
    fw(24'h000000, 16'h00FF);
    rchk(FCD_OFS_STATUS, 32'h000000FF, 32'h000000B0);
    mchk(0, 1);
    `CHK(starts, s0)
    bus(1'b1, FCD_OFS_ADDR, 32'h00000000);
    rchk(FCD_OFS_READ, 32'h000000FF, 32'h00000080);
    oe_n <= 1'b0;
    repeat (8) @(posedge clock);
    rchk(FCD_OFS_READ, 32'h000000FF, 32'h000000B0);
    fw(24'h000000, 16'h0050);
    rchk(FCD_OFS_STATUS, 32'h000000FF, 32'h00000080);
    bus(1'b1, FCD_OFS_ADDR, 32'h00000000);
    rchk(FCD_OFS_READ, 32'h000000FF, 32'h000000B0);
    ce_n <= 1'b0;
    repeat (8) @(posedge clock);
    rchk(FCD_OFS_READ, 32'h000000FF, 32'h00000080);
    $display("erase and sequence error test done");
    for (int i = 0; i < 2; i++) begin
      err_mask <= i ? 8'h00 : 8'h10;
      fw(24'h000010, 16'h0040);
      fw(24'h000010, 16'h0042);
      idle();
      rchk(FCD_OFS_STATUS, 32'h000000FF, 32'h00000090);
    end
    addr_valid_n <= 1'b0;
    repeat (8) @(posedge clock);
    rchk(FCD_OFS_READ, 32'h000000FF, 32'h00000090);
    fw(24'h000000, 16'h0050);
    rchk(FCD_OFS_STATUS, 32'h000000FF, 32'h00000080);
    $display("status clear test done");
    run_len <= 16'h0028;
    fw(24'h400300, 16'h00E8);
    fw(24'h400300, 16'h001F);
    for (int i = 0; i < 32; i++) fw(24'h400300, 16'hA500 + i);
    fw(24'h400300, 16'h00D0);
    `CHK(last_op.kind, FCD_OP_BUFFER)
    `CHK(last_op.count, 5'h1F)
    `CHK(last_op.addr, 24'h400300)
    idle();
    for (int i = 0; i < 32; i++) `CHK(engine.got[i], 16'hA500 + i)
    fw(24'h400300, 16'h00E8);
    fw(24'h400300, 16'h0020);
    rchk(FCD_OFS_STATUS, 32'h000000FF, 32'h000000B0);
    fw(24'h400300, 16'h0050);
    $display("buffer test done");
    run_len <= 16'h00C8;
    fw(24'h800040, 16'h0080);
    fw(24'h800040, 16'h00D0);
    `CHK(last_op.kind, FCD_OP_FACTORY)
    `CHK(last_op.data, 16'h00D0)
    `CHK(last_op.addr, 24'h800040)
    s0 = starts;
    fw(24'hC00000, 16'h00FF);
    mchk(3, 1);
    fw(24'h000000, 16'h0040);
    fw(24'h000000, 16'h0005);
    `CHK(starts, s0)
    idle();
    $display("factory test done");
    stop_test();
  end
endmodule : test_flash_command_decoder

// [verilog/fcd_flash_command_decoder.sv]
// command user interface of a multi-partition nor flash, behind an ahb-lite slave
// assumes write state machine, array, identifier and query data on the same clock;
// chip_enable_n, output_enable_n and address_valid_n come straight from pins
`timescale 1ns/1ns
module fcd_flash_command_decoder
  import fcd_pkg::*;
#(
  parameter int NUM_PART = 4,
  parameter int PART_W = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic address_valid_n,
  input wire logic [15:0] array_data,
  input wire logic [15:0] ident_data,
  input wire logic [15:0] query_data,
  input wire logic eng_busy,
  input wire logic [7:0] eng_error_set,
  input wire logic [FCD_CNT_W-1:0] buf_rd_idx,
  output logic [15:0] buf_rd_data,
  output logic op_start,
  output fcd_op_t op,
  output logic suspend_req
);

  typedef enum logic [2:0] {
    FCD_ST_IDLE,
    FCD_ST_WORD_SETUP,
    FCD_ST_ERASE_SETUP,
    FCD_ST_BUF_COUNT,
    FCD_ST_BUF_LOAD,
    FCD_ST_BUF_CONFIRM,
    FCD_ST_FACTORY_SETUP
  } fcd_state_t;

  // partition of a flash word address
  function automatic logic [PART_W-1:0] part_of(input logic [FCD_ADDR_W-1:0] a);
    part_of = a[FCD_ADDR_W-1 -: PART_W];
  endfunction : part_of

  // ------------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------------
  fcd_ahb_req_t req;
  fcd_ahb_req_t next_req;
  logic [FCD_ADDR_W-1:0] cmd_addr;
  logic [FCD_ADDR_W-1:0] next_cmd_addr;
  logic [31:0] next_hrdata;
  logic cmd_wr;
  logic [15:0] cmd_word;
  logic [7:0] code;
  logic [7:0] status_view;
  logic [2*NUM_PART-1:0] modes_view;
  logic [15:0] read_word;
  fcd_mode_t modes [NUM_PART];

  // zero wait state, never an error
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // write cycle toward the decoder happens in the data phase
  assign cmd_wr = req.valid && req.write && (req.addr == FCD_OFS_WRITE);
  assign cmd_word = hwdata[15:0];
  assign code = hwdata[7:0];

  // address phase capture, address register and registered read data
  always_comb begin
    next_req.valid = hsel && htrans[1] && hready;
    next_req.write = hwrite;
    next_req.addr = haddr[7:0];
    next_cmd_addr = cmd_addr;
    if (req.valid && req.write && (req.addr == FCD_OFS_ADDR)) begin
      next_cmd_addr = hwdata[FCD_ADDR_W-1:0];
    end
    next_hrdata = hrdata;
    if (next_req.valid && !hwrite) begin
      if (haddr[7:0] == FCD_OFS_ADDR) begin
        next_hrdata = {{(32-FCD_ADDR_W){1'b0}}, cmd_addr};
      end else if (haddr[7:0] == FCD_OFS_STATUS) begin
        next_hrdata = {24'h000000, status_view};
      end else if (haddr[7:0] == FCD_OFS_MODES) begin
        next_hrdata = 32'h00000000;
        next_hrdata[2*NUM_PART-1:0] = modes_view;
      end else if (haddr[7:0] == FCD_OFS_READ) begin
        next_hrdata = {16'h0000, read_word};
      end else begin
        next_hrdata = 32'h00000000; // unmapped and write-only read as zero
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req <= '0;
      cmd_addr <= '0;
      hrdata <= 32'h00000000;
    end else begin
      req <= next_req;
      cmd_addr <= next_cmd_addr;
      hrdata <= next_hrdata;
    end
  end

  // ------------------------------------------------------------------
  // pin synchronisers and status refresh
  // ------------------------------------------------------------------
  logic [2:0] pin_in;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_level;
  logic [2:0] next_pin_level;
  logic pin_toggle;
  logic [7:0] status_snap;
  logic [7:0] next_status_snap;

  assign pin_in = {address_valid_n, output_enable_n, chip_enable_n};

  // three stages per pin; the first is seen only by the second
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          sync1[g] <= 1'b1;
          sync2[g] <= 1'b1;
          sync3[g] <= 1'b1;
        end else begin
          sync1[g] <= pin_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
      assign next_pin_level[g] = (sync2[g] == sync3[g]) ? sync3[g] : pin_level[g];
    end
  endgenerate

  // a toggle of any of the three pins, enables or address valid, is the only moment the snapshot moves
  assign pin_toggle = |(next_pin_level ^ pin_level);

  always_comb begin
    next_status_snap = status_snap;
    if (pin_toggle) begin
      next_status_snap = status_view;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_level <= 3'b111;
      status_snap <= FCD_STATUS_RESET;
    end else begin
      pin_level <= next_pin_level;
      status_snap <= next_status_snap;
    end
  end

  // ------------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------------
  fcd_state_t state;
  fcd_state_t next_state;
  fcd_mode_t next_modes [NUM_PART];
  logic [7:0] err;
  logic [7:0] next_err;
  logic [7:0] err_set;
  logic err_clear;
  fcd_op_t next_op;
  logic next_op_start;
  logic next_suspend;
  logic [FCD_ADDR_W-1:0] setup_addr;
  logic [FCD_ADDR_W-1:0] next_setup_addr;
  logic [FCD_CNT_W-1:0] load_cnt;
  logic [FCD_CNT_W-1:0] next_load_cnt;
  logic [FCD_CNT_W-1:0] load_idx;
  logic [FCD_CNT_W-1:0] next_load_idx;
  logic factory_on;
  logic next_factory_on;
  logic [PART_W-1:0] busy_part;
  logic [PART_W-1:0] next_busy_part;
  logic buf_we;
  logic [PART_W-1:0] wr_part;
  logic busy_hit;

  assign wr_part = part_of(cmd_addr);
  assign busy_hit = eng_busy && (wr_part == busy_part);

  always_comb begin
    next_state = state;
    for (int i = 0; i < NUM_PART; i++) begin
      next_modes[i] = modes[i];
    end
    next_op = op;
    next_op_start = 1'b0;
    next_suspend = 1'b0;
    next_setup_addr = setup_addr;
    next_load_cnt = load_cnt;
    next_load_idx = load_idx;
    next_busy_part = busy_part;
    buf_we = 1'b0;
    err_set = 8'h00;
    err_clear = 1'b0;
    // factory mode lasts until the engine drops busy after taking it
    next_factory_on = factory_on && (eng_busy || op_start);
    if (cmd_wr && !factory_on) begin
      if (busy_hit) begin
        if (code == FCD_CMD_READ_STATUS) begin
          next_modes[wr_part] = FCD_MODE_STATUS;
        end else if (code == FCD_CMD_SUSPEND) begin
          next_suspend = 1'b1;
        end
      end else begin
        case (state)
          FCD_ST_IDLE: begin
            next_setup_addr = cmd_addr;
            if (code == FCD_CMD_READ_ARRAY) begin
              next_modes[wr_part] = FCD_MODE_ARRAY;
            end else if (code == FCD_CMD_READ_STATUS) begin
              next_modes[wr_part] = FCD_MODE_STATUS;
            end else if (code == FCD_CMD_READ_IDENT) begin
              next_modes[wr_part] = FCD_MODE_IDENT;
            end else if (code == FCD_CMD_READ_QUERY) begin
              next_modes[wr_part] = FCD_MODE_QUERY;
            end else if (code == FCD_CMD_CLEAR_STATUS) begin
              err_clear = 1'b1;
            end else if (code == FCD_CMD_SUSPEND) begin
              next_suspend = 1'b1;
            end else if (!eng_busy && !op_start) begin
              // one engine: setups are refused while any operation runs or is just starting
              if (code == FCD_CMD_WORD_PROG || code == FCD_CMD_WORD_PROG_ALT) begin
                next_state = FCD_ST_WORD_SETUP;
                next_modes[wr_part] = FCD_MODE_STATUS;
              end else if (code == FCD_CMD_BUF_PROG) begin
                next_state = FCD_ST_BUF_COUNT;
                next_modes[wr_part] = FCD_MODE_STATUS;
              end else if (code == FCD_CMD_FACTORY) begin
                next_state = FCD_ST_FACTORY_SETUP;
                next_modes[wr_part] = FCD_MODE_STATUS;
              end else if (code == FCD_CMD_ERASE) begin
                next_state = FCD_ST_ERASE_SETUP;
                next_modes[wr_part] = FCD_MODE_STATUS;
              end
            end
          end
          FCD_ST_WORD_SETUP: begin
            next_op = '{FCD_OP_WORD, cmd_addr, cmd_word, '0};
            next_op_start = 1'b1;
            next_busy_part = wr_part;
            next_modes[wr_part] = FCD_MODE_STATUS;
            next_state = FCD_ST_IDLE;
          end
          FCD_ST_ERASE_SETUP: begin
            next_modes[wr_part] = FCD_MODE_STATUS;
            if (code == FCD_CMD_CONFIRM) begin
              next_op = '{FCD_OP_ERASE, cmd_addr, cmd_word, '0};
              next_op_start = 1'b1;
              next_busy_part = wr_part;
            end else begin
              err_set = FCD_SB_SEQ_ERR;
            end
            next_state = FCD_ST_IDLE;
          end
          FCD_ST_BUF_COUNT: begin
            if (cmd_word[15:FCD_CNT_W] != '0) begin
              err_set = FCD_SB_SEQ_ERR; // count above the buffer size
              next_state = FCD_ST_IDLE;
            end else begin
              next_load_cnt = cmd_word[FCD_CNT_W-1:0];
              next_load_idx = '0;
              next_state = FCD_ST_BUF_LOAD;
            end
          end
          FCD_ST_BUF_LOAD: begin
            buf_we = 1'b1;
            next_load_idx = load_idx + 1'b1;
            if (load_idx == load_cnt) begin
              next_state = FCD_ST_BUF_CONFIRM;
            end
          end
          FCD_ST_BUF_CONFIRM: begin
            if (code == FCD_CMD_CONFIRM) begin
              next_op = '{FCD_OP_BUFFER, setup_addr, cmd_word, load_cnt};
              next_op_start = 1'b1;
              next_busy_part = part_of(setup_addr);
            end else begin
              err_set = FCD_SB_SEQ_ERR;
            end
            next_state = FCD_ST_IDLE;
          end
          FCD_ST_FACTORY_SETUP: begin
            if (code == FCD_CMD_CONFIRM) begin
              next_op = '{FCD_OP_FACTORY, cmd_addr, cmd_word, '0};
              next_op_start = 1'b1;
              next_busy_part = wr_part;
              next_factory_on = 1'b1;
            end else begin
              err_set = FCD_SB_SEQ_ERR;
            end
            next_state = FCD_ST_IDLE;
          end
          default: begin
            next_state = FCD_ST_IDLE;
          end
        endcase
      end
    end
    // a hardware set in the clearing cycle survives the clear
    next_err = (err_clear ? 8'h00 : err) | eng_error_set | err_set;
    next_err[FCD_SB_READY] = 1'b0;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= FCD_ST_IDLE;
      for (int i = 0; i < NUM_PART; i++) begin
        modes[i] <= FCD_MODE_ARRAY;
      end
      err <= 8'h00;
      op <= '0;
      op_start <= 1'b0;
      suspend_req <= 1'b0;
      setup_addr <= '0;
      load_cnt <= '0;
      load_idx <= '0;
      factory_on <= 1'b0;
      busy_part <= '0;
    end else begin
      state <= next_state;
      modes <= next_modes;
      err <= next_err;
      op <= next_op;
      op_start <= next_op_start;
      suspend_req <= next_suspend;
      setup_addr <= next_setup_addr;
      load_cnt <= next_load_cnt;
      load_idx <= next_load_idx;
      factory_on <= next_factory_on;
      busy_part <= next_busy_part;
    end
  end

  // ------------------------------------------------------------------
  // status view, mode view and read data path
  // ------------------------------------------------------------------
  // ready is live; after reset this gives the value 80
  assign status_view = {~eng_busy, err[6:0]};

  generate
    for (g = 0; g < NUM_PART; g++) begin : g_modes
      assign modes_view[2*g +: 2] = modes[g];
    end
  endgenerate

  // what a read at the address register would put on the data lines
  always_comb begin
    case (modes[wr_part])
      FCD_MODE_ARRAY: read_word = array_data;
      FCD_MODE_STATUS: read_word = {8'h00, status_snap};
      FCD_MODE_IDENT: read_word = ident_data;
      default: read_word = {8'h00, query_data[7:0]};
    endcase
  end

  fcd_program_buffer #(
    .WORDS(FCD_BUF_WORDS),
    .IDX_W(FCD_CNT_W)
  ) u_buffer (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(buf_we),
    .wr_idx(load_idx),
    .wr_data(cmd_word),
    .rd_idx(buf_rd_idx),
    .rd_data(buf_rd_data)
  );

endmodule : fcd_flash_command_decoder

// [verilog/fcd_program_buffer.sv]
// program buffer of flip-flops, one write port and one registered read port
// assumes the decoder writes and the write state machine reads on one clock
`timescale 1ns/1ns
module fcd_program_buffer
  import fcd_pkg::*;
#(
  parameter int WORDS = FCD_BUF_WORDS,
  parameter int IDX_W = FCD_CNT_W
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [15:0] rd_data
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [15:0] mem [WORDS];
  logic [15:0] next_mem [WORDS];
  logic [15:0] next_rd_data;

  // next values of the words and of the read port
  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      next_mem[i] = mem[i];
    end
    if (wr_en) begin
      next_mem[wr_idx] = wr_data;
    end
    next_rd_data = mem[rd_idx];
  end

  // registers only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= 16'h0000;
      end
      rd_data <= 16'h0000;
    end else begin
      mem <= next_mem;
      rd_data <= next_rd_data;
    end
  end

endmodule : fcd_program_buffer
